// *** core/fifo9_core.v ***
// nine-bit first-in first-out buffer with write and read ports on pin clocks
// assumes: write and read clocks arrive as pins far slower than clk_i;
// every pin is sampled through two flops and clock edges are found here
`timescale 1ns/100ps
`default_nettype none
`include "fifo9_defines.vh"

module fifo9_core #(
    parameter DEPTH = 512,
    parameter AW = 9
) (
    // system clock, reset, enable
    input wire clk_i,
    input wire reset_i,
    input wire ce_i,
    // write port pins
    input wire write_clk_i,
    input wire write_enable_primary_n_i,
    input wire write_enable_second_or_load_i,
    input wire [`DATA_W-1:0] data_in_bus_i,
    // read port pins
    input wire read_clk_i,
    input wire read_enable_a_n_i,
    input wire read_enable_b_n_i,
    input wire output_enable_n_i,
    // device reset pin
    input wire reset_n_pin_i,
    // data out, three-state as value and enable
    output wire [`DATA_W-1:0] data_out_bus_o,
    output wire data_out_bus_oe_o,
    // flags, all active low
    output wire empty_flag_n_o,
    output wire almost_empty_flag_n_o,
    output wire full_flag_n_o,
    output wire almost_full_flag_n_o
);

    localparam [AW:0] DEPTH_C = DEPTH;
    localparam [16:0] DEPTH17 = DEPTH;
    localparam [AW:0] PTR_ONE = 1;

    function [AW:0] bin2gray;
        input [AW:0] b;
        begin
            bin2gray = b ^ (b >> 1);
        end
    endfunction

    function [AW:0] gray2bin;
        input [AW:0] g;
        integer k;
        begin
            gray2bin[AW] = g[AW];
            for (k = AW - 1; k >= 0; k = k - 1) begin
                gray2bin[k] = gray2bin[k+1] ^ g[k];
            end
        end
    endfunction

    // pin synchronisation
    wire [`PIN_W-1:0] pins_raw;
    wire [`PIN_W-1:0] pins_s;

    assign pins_raw = {data_in_bus_i, output_enable_n_i, read_enable_b_n_i, read_enable_a_n_i,
                       write_enable_second_or_load_i, write_enable_primary_n_i, reset_n_pin_i,
                       read_clk_i, write_clk_i};

    pin_sync2 #(
        .WIDTH(`PIN_W)
    ) u_pin_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .async_i(pins_raw),
        .sync_o(pins_s)
    );

    wire wclk_s = pins_s[`PIN_WCLK];
    wire rclk_s = pins_s[`PIN_RCLK];
    wire rs_n_s = pins_s[`PIN_RS_N];
    wire write_enable_primary_n_n_s = pins_s[`PIN_WRITE_ENABLE_PRIMARY_N_N];
    wire wen2_s = pins_s[`PIN_WEN2];
    wire ren_a_n_s = pins_s[`PIN_REN_A_N];
    wire ren_b_n_s = pins_s[`PIN_REN_B_N];
    wire oe_n_s = pins_s[`PIN_OE_N];
    wire [`DATA_W-1:0] din_s = pins_s[`PIN_DATA_HI:`PIN_DATA_LO];

    // state
    reg wclk_prev_q;
    reg rclk_prev_q;
    reg mode_q;
    reg [AW:0] wbin_q;
    reg [AW:0] wgray_q;
    reg [AW:0] rbin_q;
    reg [AW:0] rgray_q;
    reg [AW:0] wsync1_q;
    reg [AW:0] wsync2_q;
    reg [AW:0] rsync1_q;
    reg [AW:0] rsync2_q;
    reg [1:0] wsel_q;
    reg [1:0] rsel_q;
    reg [`OFFSET_W-1:0] off_q [0:3];
    reg [`DATA_W-1:0] dout_q;
    reg oe_q;
    reg empty_n_q;
    reg almost_empty_n_q;
    reg full_n_q;
    reg almost_full_n_q;
    reg [`DATA_W-1:0] mem [0:DEPTH-1];
    integer i;

    // edge finding on the sampled pin clocks; two clk_i cycles late, same for data
    wire wr_edge = wclk_s & ~wclk_prev_q;
    wire rd_edge = rclk_s & ~rclk_prev_q;

    wire pflag = (mode_q == `MODE_PFLAG);
    wire load_mode = pflag & ~wen2_s;
    wire wr_req = ~write_enable_primary_n_n_s & (pflag | wen2_s);
    wire rd_req = ~ren_a_n_s & ~ren_b_n_s;
    wire run = rs_n_s;

    wire off_we = run & wr_edge & load_mode & ~write_enable_primary_n_n_s;
    wire off_re = run & rd_edge & load_mode & rd_req;
    wire mem_we = run & wr_edge & ~load_mode & wr_req & full_n_q;
    wire mem_re = run & rd_edge & ~load_mode & rd_req & empty_n_q;

    wire [15:0] empty_off = {off_q[`SEL_EMPTY_HI], off_q[`SEL_EMPTY_LO]};
    wire [15:0] full_off = {off_q[`SEL_FULL_HI], off_q[`SEL_FULL_LO]};

    // write side view
    wire [AW:0] wbin_d = mem_we ? wbin_q + PTR_ONE : wbin_q;
    wire [AW:0] wcnt = wbin_d - gray2bin(rsync2_q);
    wire [16:0] wsum = {{(16-AW){1'b0}}, wcnt} + {1'b0, full_off};

    // read side view
    wire [AW:0] rbin_d = mem_re ? rbin_q + PTR_ONE : rbin_q;
    wire [AW:0] rcnt = gray2bin(wsync2_q) - rbin_d;
    wire [15:0] rcnt16 = {{(15-AW){1'b0}}, rcnt};

    // memory has no reset; pointers alone decide what is valid
    always @(posedge clk_i) begin
        if (ce_i && mem_we && !reset_i) begin
            mem[wbin_q[AW-1:0]] <= din_s;
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            wclk_prev_q <= 1'b0;
            rclk_prev_q <= 1'b0;
            mode_q <= `MODE_TWO_EN;
            wbin_q <= {(AW+1){1'b0}};
            wgray_q <= {(AW+1){1'b0}};
            rbin_q <= {(AW+1){1'b0}};
            rgray_q <= {(AW+1){1'b0}};
            wsync1_q <= {(AW+1){1'b0}};
            wsync2_q <= {(AW+1){1'b0}};
            rsync1_q <= {(AW+1){1'b0}};
            rsync2_q <= {(AW+1){1'b0}};
            wsel_q <= `SEL_EMPTY_LO;
            rsel_q <= `SEL_EMPTY_LO;
            for (i = 0; i < 4; i = i + 1) begin
                off_q[i] <= `OFFSET_ZERO;
            end
            off_q[`SEL_EMPTY_LO] <= `OFFSET_DEFAULT;
            off_q[`SEL_FULL_LO] <= `OFFSET_DEFAULT;
            dout_q <= `DATA_RESET;
            oe_q <= 1'b0;
            empty_n_q <= 1'b0;
            almost_empty_n_q <= 1'b0;
            full_n_q <= 1'b1;
            almost_full_n_q <= 1'b1;
        end else if (ce_i) begin
            wclk_prev_q <= wclk_s;
            rclk_prev_q <= rclk_s;
            oe_q <= ~oe_n_s;
            if (!rs_n_s) begin
                // strap caught on every cycle of the pin reset
                mode_q <= wen2_s ? `MODE_TWO_EN : `MODE_PFLAG;
                wbin_q <= {(AW+1){1'b0}};
                wgray_q <= {(AW+1){1'b0}};
                rbin_q <= {(AW+1){1'b0}};
                rgray_q <= {(AW+1){1'b0}};
                wsync1_q <= {(AW+1){1'b0}};
                wsync2_q <= {(AW+1){1'b0}};
                rsync1_q <= {(AW+1){1'b0}};
                rsync2_q <= {(AW+1){1'b0}};
                wsel_q <= `SEL_EMPTY_LO;
                rsel_q <= `SEL_EMPTY_LO;
                for (i = 0; i < 4; i = i + 1) begin
                    off_q[i] <= `OFFSET_ZERO;
                end
                off_q[`SEL_EMPTY_LO] <= `OFFSET_DEFAULT;
                off_q[`SEL_FULL_LO] <= `OFFSET_DEFAULT;
                dout_q <= `DATA_RESET;
                empty_n_q <= 1'b0;
                almost_empty_n_q <= 1'b0;
                full_n_q <= 1'b1;
                almost_full_n_q <= 1'b1;
            end else begin
                if (wr_edge) begin
                    // read pointer enters the write side in two write-edge stages
                    rsync1_q <= rgray_q;
                    rsync2_q <= rsync1_q;
                    wbin_q <= wbin_d;
                    wgray_q <= bin2gray(wbin_d);
                    full_n_q <= (wcnt != DEPTH_C);
                    almost_full_n_q <= (wsum < DEPTH17);
                    if (off_we) begin
                        off_q[wsel_q] <= din_s[`OFFSET_W-1:0];
                        wsel_q <= wsel_q + `SEL_STEP;
                    end
                end
                if (rd_edge) begin
                    wsync1_q <= wgray_q;
                    wsync2_q <= wsync1_q;
                    rbin_q <= rbin_d;
                    rgray_q <= bin2gray(rbin_d);
                    empty_n_q <= (rcnt != {(AW+1){1'b0}});
                    almost_empty_n_q <= (rcnt16 > empty_off);
                    if (off_re) begin
                        dout_q <= {1'b0, off_q[rsel_q]};
                        rsel_q <= rsel_q + `SEL_STEP;
                    end else if (mem_re) begin
                        dout_q <= mem[rbin_q[AW-1:0]];
                    end
                    // otherwise dout_q holds the last valid read
                end
            end
        end
    end

    assign data_out_bus_o = dout_q;
    assign data_out_bus_oe_o = oe_q;
    assign empty_flag_n_o = empty_n_q;
    assign almost_empty_flag_n_o = almost_empty_n_q;
    assign full_flag_n_o = full_n_q;
    assign almost_full_flag_n_o = almost_full_n_q;

endmodule // fifo9_core

`default_nettype wire

// *** core/pin_sync2.v ***
// two-flop synchroniser for a vector of pin inputs
// assumes: each bit is an independent level from outside clk_i
`timescale 1ns/100ps
`default_nettype none

module pin_sync2 #(
    parameter WIDTH = 1
) (
    // clock, reset, enable
    input wire clk_i,
    input wire reset_i,
    input wire ce_i,
    // pins in, synchronised levels out
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // meta_q is read by sync_q only
    always @(posedge clk_i) begin
        if (reset_i) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else if (ce_i) begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // pin_sync2

`default_nettype wire

// *** inc/fifo9_defines.vh ***
// constants shared by the nine-bit dual-port buffer core
// assumes: included by bare name from files under core/
// How it works
// - two-enable mode writes while enable low, second high
// - input and output words nine bits wide
// - depth is a parameter, 256 or 512
// - flag mode: primary enable alone gates writes
// - writes ignored while full
// - reads ignored while empty
// - output holds last valid read word
// - both read enables low pops next word
// - second enable pin sampled at reset picks mode
// - load low: writes fill offset registers
// - load low: reads show offset registers
// - four eight-bit offset registers
// - empty flags change only on read edges
// - full flags change only on write edges
// - thresholds per word, default seven
// - reset empties buffer, outputs driven low
// - flags valid during reset, outputs low after
// - output enable low drives outputs, else released
// - write and read clocks independent
// - offset writes cycle four registers, position kept
// - almost-empty low at n or fewer words
// - almost-full low at depth minus m
`ifndef FIFO9_DEFINES_VH
`define FIFO9_DEFINES_VH

`define DATA_W 9
`define OFFSET_W 8
`define OFFSET_DEFAULT 8'h07
`define OFFSET_ZERO 8'h00
`define DATA_RESET 9'h000

// offset register order
`define SEL_EMPTY_LO 2'h0
`define SEL_EMPTY_HI 2'h1
`define SEL_FULL_LO 2'h2
`define SEL_FULL_HI 2'h3
`define SEL_STEP 2'h1

// configuration caught at reset
`define MODE_TWO_EN 1'b0
`define MODE_PFLAG 1'b1

// positions in the synchronised pin vector
`define PIN_W 17
`define PIN_WCLK 0
`define PIN_RCLK 1
`define PIN_RS_N 2
`define PIN_WRITE_ENABLE_PRIMARY_N_N 3
`define PIN_WEN2 4
`define PIN_REN_A_N 5
`define PIN_REN_B_N 6
`define PIN_OE_N 7
`define PIN_DATA_LO 8
`define PIN_DATA_HI 16

`endif

// *** tb/fifo9_core_assertions.sv ***
// assertions on the buffer core pins, bound to each core instance
// assumes: pin clocks and pin reset change far slower than clk_i
`timescale 1ns/100ps
`default_nettype none

module fifo9_core_checker (
    // clock, reset
    input wire logic clk_i,
    input wire logic reset_i,
    // pins in
    input wire logic write_clk_i,
    input wire logic read_clk_i,
    input wire logic output_enable_n_i,
    input wire logic reset_n_pin_i,
    // pins out
    input wire logic [8:0] data_out_bus_o,
    input wire logic data_out_bus_oe_o,
    input wire logic empty_flag_n_o,
    input wire logic almost_empty_flag_n_o,
    input wire logic full_flag_n_o,
    input wire logic almost_full_flag_n_o
);
    // six cycles of history span pin sync plus edge detect
    logic [5:0] rd_q, wr_q, rs_q;
    always @(posedge clk_i) begin
        rd_q <= {rd_q[4:0], read_clk_i};
        wr_q <= {wr_q[4:0], write_clk_i};
        rs_q <= {rs_q[4:0], !reset_n_pin_i};
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    reset_state_a: assert property ($fell(reset_i) |-> data_out_bus_o == 9'h000 && !empty_flag_n_o
        && !almost_empty_flag_n_o && full_flag_n_o && almost_full_flag_n_o) else $error("bad reset state");
    empty_side_a: assert property ($changed({empty_flag_n_o, almost_empty_flag_n_o}) |-> |rd_q || |rs_q)
        else $error("empty flags moved off read edge");
    full_side_a: assert property ($changed({full_flag_n_o, almost_full_flag_n_o}) |-> |wr_q || |rs_q)
        else $error("full flags moved off write edge");
    data_hold_a: assert property ($changed(data_out_bus_o) |-> |rd_q || |rs_q)
        else $error("output word moved off read edge");
    drive_on_a: assert property ((!output_enable_n_i)[*5] |-> data_out_bus_oe_o)
        else $error("outputs not driven");
    drive_off_a: assert property (output_enable_n_i[*5] |-> !data_out_bus_oe_o)
        else $error("outputs not released");
    empty_almost_a: assert property (!empty_flag_n_o |-> !almost_empty_flag_n_o)
        else $error("empty without almost empty");
    full_almost_a: assert property (!full_flag_n_o |-> !almost_full_flag_n_o)
        else $error("full without almost full");
endmodule // fifo9_core_checker

bind fifo9_core fifo9_core_checker chk (.clk_i, .reset_i, .write_clk_i, .read_clk_i, .output_enable_n_i,
    .reset_n_pin_i, .data_out_bus_o, .data_out_bus_oe_o, .empty_flag_n_o, .almost_empty_flag_n_o,
    .full_flag_n_o, .almost_full_flag_n_o);

`default_nettype wire

// *** tb/fifo9_core_test.sv ***
// bench for the buffer core: word order, flags, offsets, output enable
// assumes: fifo9_pins_model paces the pins; the checker comes by bind
`timescale 1ns/100ps
`default_nettype none

module fifo9_core_test;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce_i = 1'b1;
    logic load = 1'b1;
    logic reset_n_pin_i = 1'b1;
    logic output_enable_n_i = 1'b0;
    logic [8:0] offs [4] = '{9'h004, 9'h000, 9'h002, 9'h000};
    wire logic write_clk_i, write_enable_primary_n_i, read_clk_i, read_enable_a_n_i, read_enable_b_n_i;
    wire logic data_out_bus_oe_o, empty_flag_n_o, almost_empty_flag_n_o, full_flag_n_o, almost_full_flag_n_o;
    wire logic [8:0] data_in_bus_i, data_out_bus_o;
    int fail_count = 0;
    int compares = 0;
    int i;

    fifo9_core #(.DEPTH(512), .AW(9)) uut (.clk_i, .reset_i, .ce_i, .write_clk_i, .write_enable_primary_n_i,
        .write_enable_second_or_load_i(load), .data_in_bus_i, .read_clk_i, .read_enable_a_n_i,
        .read_enable_b_n_i, .output_enable_n_i, .reset_n_pin_i, .data_out_bus_o, .data_out_bus_oe_o,
        .empty_flag_n_o, .almost_empty_flag_n_o, .full_flag_n_o, .almost_full_flag_n_o);
    fifo9_pins_model pins (.clk_i, .wclk_o(write_clk_i), .wen_n_o(write_enable_primary_n_i),
        .data_o(data_in_bus_i), .rclk_o(read_clk_i), .ren_a_n_o(read_enable_a_n_i), .ren_b_n_o(read_enable_b_n_i));

    always #25 clk_i = ~clk_i;

    task automatic stop_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // sampled mid-cycle so the edge's updates have landed
    task automatic chk_word(input logic [8:0] exp);
        @(negedge clk_i);
        compares++;
        if (data_out_bus_o !== exp) begin
            fail_count++;
            $display("unexpected data_out_bus expected %h seen %h", exp, data_out_bus_o);
        end
        @(posedge clk_i);
    endtask
    // order: drive, empty, almost empty, full, almost full
    task automatic chk_pins(input logic [4:0] exp);
        @(negedge clk_i);
        compares++;
        if ({data_out_bus_oe_o, empty_flag_n_o, almost_empty_flag_n_o, full_flag_n_o,
             almost_full_flag_n_o} !== exp) begin
            fail_count++;
            $display("unexpected flags expected %h seen %h", exp, {data_out_bus_oe_o, empty_flag_n_o,
                almost_empty_flag_n_o, full_flag_n_o, almost_full_flag_n_o});
        end
        @(posedge clk_i);
    endtask
    // read clock edges with both enables off just move the read side
    task automatic ticks(input int n);
        repeat (n) pins.pull(1'b1, 1'b1);
    endtask
    // no pin clock runs while the pin reset is low
    task automatic pin_reset(input logic strap);
        load <= strap;
        reset_n_pin_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        reset_n_pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask

    initial begin
        repeat (30000) @(posedge clk_i);
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        pin_reset(1'b1);
        chk_pins(5'h13);
        chk_word(9'h000);
        load <= 1'b0; // expansion side holds its enable off
        pins.push(9'h155, 1'b0);
        ticks(3);
        chk_pins(5'h13);
        load <= 1'b1;
        // primary enable high must not store, second enable alone is not enough
        pins.push(9'h0aa, 1'b1);
        ticks(3);
        chk_pins(5'h13);
        for (i = 0; i < 512; i++) begin
            pins.push(i[8:0] ^ 9'h1a5, 1'b0);
            if (i == 0) chk_pins(5'h13);
            if (i == 6 || i == 7) begin
                ticks(3);
                chk_pins(i == 6 ? 5'h1b : 5'h1f);
            end
            if (i > 502 && (i < 505 || i > 509)) chk_pins(i == 503 ? 5'h1f : i == 511 ? 5'h1c : 5'h1e);
        end
        pins.push(9'h0f0, 1'b0);
        chk_pins(5'h1c);
        pins.pull(1'b0, 1'b1);
        chk_word(9'h000);
        for (i = 0; i < 512; i++) begin
            pins.pull(1'b0, 1'b0);
            chk_word(i[8:0] ^ 9'h1a5);
        end
        chk_pins(5'h10);
        pins.pull(1'b0, 1'b0);
        chk_word(9'h05a);
        output_enable_n_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk_pins(5'h00);
        output_enable_n_i <= 1'b0;
        pin_reset(1'b0);
        chk_pins(5'h13);
        pins.push(9'h1ff, 1'b0);
        pins.push(9'h000, 1'b0);
        pins.push(9'h002, 1'b0);
        pins.push(9'h000, 1'b0);
        pins.push(9'h104, 1'b0);
        for (i = 0; i < 4; i++) begin
            pins.pull(1'b0, 1'b0);
            chk_word(offs[i]);
        end
        ticks(3);
        chk_pins(5'h13);
        load <= 1'b1;
        for (i = 0; i < 5; i++) begin
            pins.push(i[8:0], 1'b0);
            if (i > 2) begin
                ticks(3);
                chk_pins(i == 3 ? 5'h1b : 5'h1f);
            end
        end
        pin_reset(1'b0);
        // a frozen core misses the whole read clock pulse, so no offset is shown
        ce_i <= 1'b0;
        pins.pull(1'b0, 1'b0);
        ce_i <= 1'b1;
        chk_word(9'h000);
        for (i = 0; i < 4; i++) begin
            pins.pull(1'b0, 1'b0);
            chk_word(i[0] ? 9'h000 : 9'h007);
        end
        stop_test();
    end
endmodule // fifo9_core_test

`default_nettype wire

// *** tb/fifo9_pins_model.sv ***
// producer and consumer pin model beside the buffer core
// assumes: tasks start just after a clk_i rise; a pin clock phase is 4 cycles
`timescale 1ns/100ps
`default_nettype none

module fifo9_pins_model (
    // pacing clock
    input wire logic clk_i,
    // write port
    output var logic wclk_o,
    output var logic wen_n_o,
    output var logic [8:0] data_o,
    // read port
    output var logic rclk_o,
    output var logic ren_a_n_o,
    output var logic ren_b_n_o
);
    initial {wclk_o, wen_n_o, data_o, rclk_o, ren_a_n_o, ren_b_n_o} = 14'h1003;
    // one task at a time, so offsets never see read and write together
    task automatic push(input logic [8:0] d, input logic en_n);
        data_o <= d;
        wen_n_o <= en_n;
        repeat (4) @(posedge clk_i);
        wclk_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        wclk_o <= 1'b0;
    endtask
    task automatic pull(input logic a_n, input logic b_n);
        ren_a_n_o <= a_n;
        ren_b_n_o <= b_n;
        repeat (4) @(posedge clk_i);
        rclk_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        rclk_o <= 1'b0;
    endtask
endmodule // fifo9_pins_model

`default_nettype wire
